// [hdl/lcr_channel.sv]
`timescale 1ns/100ps
`default_nettype none

module lcr_channel
  import lcr_pkg::*;
(
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic ce_i,
  input wire logic [7:0] cfg_i,
  input wire logic supply_low_i,
  input wire logic can_on_i,
  output logic trx_en_o,
  output logic wake_en_o,
  output logic [1:0] slew_o,
  output logic term_en_o,
  output logic force_rec_o
);

  typedef struct packed {
    logic trx;
    logic wake;
    logic [1:0] slew;
    logic term;
    logic force_rec;
  } lcr_ch_t;

  lcr_ch_t ch_reg;
  lcr_ch_t ch_next;

  always_comb begin
    ch_next = ch_reg;
    case (lcr_mode_t'(cfg_i[LCR_MODE_HI:LCR_MODE_LO]))
      LCR_MODE_TRX: begin
        ch_next.trx = 1'b1;
        ch_next.wake = 1'b0;
      end
      LCR_MODE_WAKE: begin
        ch_next.trx = 1'b0;
        ch_next.wake = 1'b1;
      end
      default: begin
        ch_next.trx = 1'b0;
        ch_next.wake = 1'b0;
      end
    endcase
    case (cfg_i[LCR_SLEW_HI:LCR_SLEW_LO])
      2'b00: ch_next.slew = LCR_SLEW_20K;
      2'b01: ch_next.slew = LCR_SLEW_10K;
      default: ch_next.slew = LCR_SLEW_FAST;
    endcase
    ch_next.term = cfg_i[LCR_TERM_POS];
    // Without extension the bus drops at low half supply; with it the
    // transceiver runs on until the CAN supply regulator goes off
    if (cfg_i[LCR_EXT_POS]) begin
      ch_next.force_rec = !can_on_i;
    end else begin
      ch_next.force_rec = supply_low_i;
    end
  end

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      ch_reg <= '0;
    end else if (ce_i) begin
      ch_reg <= ch_next;
    end
  end

  assign trx_en_o = ch_reg.trx;
  assign wake_en_o = ch_reg.wake;
  assign slew_o = ch_reg.slew;
  assign term_en_o = ch_reg.term;
  assign force_rec_o = ch_reg.force_rec;

endmodule : lcr_channel

`default_nettype wire

// [hdl/lcr_pkg.sv]
package lcr_pkg;

  // Serial frame layout, MSB first
  localparam int unsigned LCR_FRAME_BITS = 16;
  localparam int unsigned LCR_PREFIX_HI = 15;
  localparam int unsigned LCR_PREFIX_LO = 14;
  localparam int unsigned LCR_ADDR_HI = 13;
  localparam int unsigned LCR_ADDR_LO = 9;
  localparam int unsigned LCR_PARITY_POS = 8;
  localparam int unsigned LCR_DATA_HI = 7;
  localparam logic [1:0] LCR_WRITE_PREFIX = 2'h1;

  // Register addresses carried in the first command byte
  localparam logic [4:0] LCR_ADDR_LIN_FIRST = 5'h13;
  localparam logic [4:0] LCR_ADDR_LIN_SECOND = 5'h14;

  // Configuration byte fields
  localparam int unsigned LCR_MODE_HI = 7;
  localparam int unsigned LCR_MODE_LO = 6;
  localparam int unsigned LCR_SLEW_HI = 5;
  localparam int unsigned LCR_SLEW_LO = 4;
  localparam int unsigned LCR_TERM_POS = 2;
  localparam int unsigned LCR_EXT_POS = 0;
  localparam logic [7:0] LCR_USED_MASK = 8'hF5;
  localparam logic [7:0] LCR_CFG_RESET = 8'h00;

  // Pin synchroniser lanes
  localparam int unsigned LCR_NPINS = 7;
  localparam int unsigned LCR_PIN_SCLK = 0;
  localparam int unsigned LCR_PIN_CSN = 1;
  localparam int unsigned LCR_PIN_MOSI = 2;
  localparam int unsigned LCR_PIN_TXD1 = 3;
  localparam int unsigned LCR_PIN_TXD2 = 4;
  localparam int unsigned LCR_PIN_LOW = 5;
  localparam int unsigned LCR_PIN_CANON = 6;
  localparam logic [6:0] LCR_PIN_RESET = 7'h03;

  localparam logic [4:0] LCR_CNT_MAX = 5'h1F;

  typedef enum logic [1:0] {
    LCR_MODE_OFF = 2'b00,
    LCR_MODE_UNUSED = 2'b01,
    LCR_MODE_WAKE = 2'b10,
    LCR_MODE_TRX = 2'b11
  } lcr_mode_t;

  typedef enum logic [1:0] {
    LCR_SLEW_20K = 2'b00,
    LCR_SLEW_10K = 2'b01,
    LCR_SLEW_FAST = 2'b10
  } lcr_slew_t;

endpackage : lcr_pkg

// [hdl/lcr_top.sv]
`timescale 1ns/100ps
`default_nettype none

module lcr_top
  import lcr_pkg::*;
(
  input wire logic MCLK_I,
  input wire logic RESETN_I,
  input wire logic CE_I,
  input wire logic SPI_SCLK_I,
  input wire logic SPI_CS_N_I,
  input wire logic SPI_MOSI_I,
  output logic SPI_MISO_O,
  output logic SPI_MISO_OE_O,
  input wire logic LIN1_TXD_I,
  input wire logic LIN2_TXD_I,
  input wire logic SUPPLY_HALF_LOW_I,
  input wire logic CAN_SUPPLY_REGULATOR_ON_I,
  output logic LIN1_TRX_EN_O,
  output logic LIN1_WAKE_EN_O,
  output logic [1:0] LIN1_SLEW_O,
  output logic LIN1_TERM_EN_O,
  output logic LIN1_FORCE_REC_O,
  output logic LIN2_TRX_EN_O,
  output logic LIN2_WAKE_EN_O,
  output logic [1:0] LIN2_SLEW_O,
  output logic LIN2_TERM_EN_O,
  output logic LIN2_FORCE_REC_O
);

  ////////////////////////////////////////////////////////////////////////////

  typedef struct packed {
    // Pin filter: three sampling stages and the accepted level
    logic [LCR_NPINS-1:0] s0;
    logic [LCR_NPINS-1:0] s1;
    logic [LCR_NPINS-1:0] s2;
    logic [LCR_NPINS-1:0] flt;
    // Serial shifters and the count of rising serial clock edges
    logic [LCR_FRAME_BITS-1:0] sh_in;
    logic [LCR_FRAME_BITS-1:0] sh_out;
    logic [4:0] cnt;
    logic miso;
    logic miso_oe;
    // Stored configuration bytes
    logic [7:0] cfg1;
    logic [7:0] cfg2;
  } lcr_top_t;

  lcr_top_t st_reg;
  lcr_top_t st_next;

  logic [LCR_NPINS-1:0] pins;
  logic sck_rise;
  logic sck_fall;
  logic cs_start;
  logic cs_end;
  logic [4:0] wr_addr;
  logic [7:0] wr_data;
  logic frame_ok;
  // Per-channel write strobes, valid only in the cycle chip select ends
  logic wr_first;
  logic wr_second;

  assign pins = {CAN_SUPPLY_REGULATOR_ON_I, SUPPLY_HALF_LOW_I, LIN2_TXD_I,
                 LIN1_TXD_I, SPI_MOSI_I, SPI_CS_N_I, SPI_SCLK_I};

  ////////////////////////////////////////////////////////////////////////////

  // Applies a write to one channel register. Unused bits are dropped, and a
  // transmit/receive request with a dominant transmit input keeps the old
  // mode, so an off channel stays off.
  function automatic logic [7:0] cfg_write(input logic [7:0] old_cfg,
                                           input logic [7:0] data,
                                           input logic txd_recessive);
    logic [7:0] v;
    v = data & LCR_USED_MASK;
    if (v[LCR_MODE_HI:LCR_MODE_LO] == LCR_MODE_TRX && !txd_recessive) begin
      v[LCR_MODE_HI:LCR_MODE_LO] = old_cfg[LCR_MODE_HI:LCR_MODE_LO];
    end
    return v;
  endfunction : cfg_write

  ////////////////////////////////////////////////////////////////////////////

  // Frame handling. Chip select, serial clock and data are sampled through
  // the pin filter, so every serial edge is seen about four system clocks
  // late; the serial clock must stay in each level for at least two system
  // clocks or an edge is lost. Data is taken on rising serial clock edges and
  // the readback word moves on falling ones. A write lands only when chip
  // select rises after exactly sixteen rising edges, so a host that gives up
  // halfway leaves both registers untouched.
  always_comb begin
    st_next = st_reg;
    // Three-stage sampling; a level counts once stages two and three agree
    st_next.s0 = pins;
    st_next.s1 = st_reg.s0;
    st_next.s2 = st_reg.s1;
    for (int i = 0; i < LCR_NPINS; i++) begin
      if (st_reg.s1[i] == st_reg.s2[i]) begin
        st_next.flt[i] = st_reg.s2[i];
      end
    end
    // An edge is only reported between two filtered values, never from the
    // raw pin, so a glitch shorter than two system clocks is ignored
    sck_rise = !st_reg.flt[LCR_PIN_SCLK] && st_next.flt[LCR_PIN_SCLK];
    sck_fall = st_reg.flt[LCR_PIN_SCLK] && !st_next.flt[LCR_PIN_SCLK];
    cs_start = st_reg.flt[LCR_PIN_CSN] && !st_next.flt[LCR_PIN_CSN];
    cs_end = !st_reg.flt[LCR_PIN_CSN] && st_next.flt[LCR_PIN_CSN];
    wr_addr = st_reg.sh_in[LCR_ADDR_HI:LCR_ADDR_LO];
    wr_data = st_reg.sh_in[LCR_DATA_HI:0];
    // Parity in bit 8 is not checked; a frame of the wrong length is dropped
    frame_ok = (st_reg.cnt == 5'(LCR_FRAME_BITS)) &&
               (st_reg.sh_in[LCR_PREFIX_HI:LCR_PREFIX_LO] ==
                LCR_WRITE_PREFIX);
    wr_first = cs_end && frame_ok &&
               (wr_addr == LCR_ADDR_LIN_FIRST);
    wr_second = cs_end && frame_ok &&
                (wr_addr == LCR_ADDR_LIN_SECOND);

    if (cs_start) begin
      st_next.cnt = '0;
      // Readback of both registers is loaded once per frame; a write in
      // this frame is seen only by the next one
      st_next.sh_out = {st_reg.cfg1, st_reg.cfg2};
      st_next.miso = st_reg.cfg1[7];
      st_next.miso_oe = 1'b1;
    end else if (!st_reg.flt[LCR_PIN_CSN]) begin
      if (sck_rise) begin
        st_next.sh_in = {st_reg.sh_in[LCR_FRAME_BITS-2:0],
                         st_reg.flt[LCR_PIN_MOSI]};
        // The count saturates so an overlong frame cannot wrap back to 16
        if (st_reg.cnt != LCR_CNT_MAX) begin
          st_next.cnt = st_reg.cnt + 5'd1;
        end
      end
      if (sck_fall) begin
        st_next.sh_out = {st_reg.sh_out[LCR_FRAME_BITS-2:0], 1'b0};
        st_next.miso = st_reg.sh_out[LCR_FRAME_BITS-2];
      end
    end
    if (cs_end) begin
      st_next.miso_oe = 1'b0;
      st_next.miso = 1'b0;
      if (wr_first) begin
        st_next.cfg1 = cfg_write(st_reg.cfg1, wr_data,
                                 st_reg.flt[LCR_PIN_TXD1]);
      end
      if (wr_second) begin
        st_next.cfg2 = cfg_write(st_reg.cfg2, wr_data,
                                 st_reg.flt[LCR_PIN_TXD2]);
      end
    end
  end

  // A low clock enable freezes filter, shifters and registers alike; a frame
  // that overlaps it misses edges and is then dropped as too short
  always_ff @(posedge MCLK_I or negedge RESETN_I) begin
    if (!RESETN_I) begin
      st_reg <= '0;
      // Filter stages start with chip select and serial clock high, so no
      // frame is seen to start as reset ends
      st_reg.s0 <= LCR_PIN_RESET;
      st_reg.s1 <= LCR_PIN_RESET;
      st_reg.s2 <= LCR_PIN_RESET;
      st_reg.flt <= LCR_PIN_RESET;
      st_reg.cfg1 <= LCR_CFG_RESET;
      st_reg.cfg2 <= LCR_CFG_RESET;
    end else if (CE_I) begin
      st_reg <= st_next;
    end
  end

  // The readback pin is driven only while chip select is low
  assign SPI_MISO_O = st_reg.miso;
  assign SPI_MISO_OE_O = st_reg.miso_oe;

  ////////////////////////////////////////////////////////////////////////////

  // Both channels share the supply pins but each owns its register, so a
  // write to one never disturbs the other
  // The CAN regulator input is relied on to be on before LIN use
  lcr_channel u_first_channel (
    .clk_i(MCLK_I),
    .rst_n_i(RESETN_I),
    .ce_i(CE_I),
    .cfg_i(st_reg.cfg1),
    .supply_low_i(st_reg.flt[LCR_PIN_LOW]),
    .can_on_i(st_reg.flt[LCR_PIN_CANON]),
    .trx_en_o(LIN1_TRX_EN_O),
    .wake_en_o(LIN1_WAKE_EN_O),
    .slew_o(LIN1_SLEW_O),
    .term_en_o(LIN1_TERM_EN_O),
    .force_rec_o(LIN1_FORCE_REC_O)
  );

  lcr_channel u_second_channel (
    .clk_i(MCLK_I),
    .rst_n_i(RESETN_I),
    .ce_i(CE_I),
    .cfg_i(st_reg.cfg2),
    .supply_low_i(st_reg.flt[LCR_PIN_LOW]),
    .can_on_i(st_reg.flt[LCR_PIN_CANON]),
    .trx_en_o(LIN2_TRX_EN_O),
    .wake_en_o(LIN2_WAKE_EN_O),
    .slew_o(LIN2_SLEW_O),
    .term_en_o(LIN2_TERM_EN_O),
    .force_rec_o(LIN2_FORCE_REC_O)
  );

endmodule : lcr_top

`default_nettype wire

// [test/lcr_chk.sv]
`timescale 1ns/100ps
`default_nettype none
module lcr_chk (
  input wire logic MCLK_I,
  input wire logic RESETN_I,
  input wire logic SPI_CS_N_I,
  input wire logic SPI_MISO_OE_O,
  input wire logic LIN1_TXD_I,
  input wire logic SUPPLY_HALF_LOW_I,
  input wire logic CAN_SUPPLY_REGULATOR_ON_I,
  input wire logic LIN1_TRX_EN_O,
  input wire logic LIN1_WAKE_EN_O,
  input wire logic [1:0] LIN1_SLEW_O,
  input wire logic LIN1_FORCE_REC_O,
  input wire logic LIN2_TRX_EN_O,
  input wire logic LIN2_WAKE_EN_O
);
  default clocking @(posedge MCLK_I); endclocking
  default disable iff (!RESETN_I);
  property p_rst;
    // From the second edge in reset: at time zero the flops may lag
    disable iff (1'b0) !RESETN_I && $past(!RESETN_I) |->
      !LIN1_TRX_EN_O && !LIN1_WAKE_EN_O
      && !LIN2_TRX_EN_O && !LIN2_WAKE_EN_O && LIN1_SLEW_O == 2'b00;
  endproperty
  a_rst: assert property (p_rst) else $error("outputs set in reset");
  property p_excl;
    !(LIN1_TRX_EN_O && LIN1_WAKE_EN_O) && !(LIN2_TRX_EN_O && LIN2_WAKE_EN_O);
  endproperty
  a_excl: assert property (p_excl) else $error("two modes at once");
  property p_slew;
    LIN1_SLEW_O != 2'b11;
  endproperty
  a_slew: assert property (p_slew) else $error("bad slew code");
  property p_low;
    (SUPPLY_HALF_LOW_I && !CAN_SUPPLY_REGULATOR_ON_I) [*8] |-> LIN1_FORCE_REC_O;
  endproperty
  a_low: assert property (p_low) else $error("bus not forced");
  property p_ok;
    (!SUPPLY_HALF_LOW_I && CAN_SUPPLY_REGULATOR_ON_I) [*8] |-> !LIN1_FORCE_REC_O;
  endproperty
  a_ok: assert property (p_ok) else $error("bus forced wrongly");
  property p_txd;
    (!LIN1_TXD_I) [*8] ##0 !LIN1_TRX_EN_O |=> !LIN1_TRX_EN_O;
  endproperty
  a_txd: assert property (p_txd) else $error("mode set on dominant");
  property p_lat;
    $changed(LIN1_SLEW_O) |-> $past(SPI_CS_N_I, 4);
  endproperty
  a_lat: assert property (p_lat) else $error("update inside frame");
  property p_oe;
    SPI_CS_N_I [*5] |=> !SPI_MISO_OE_O;
  endproperty
  a_oe: assert property (p_oe) else $error("output on when idle");
  c_trx: cover property ($rose(LIN1_TRX_EN_O));
  c_force: cover property ($rose(LIN1_FORCE_REC_O));
  c_wake: cover property ($rose(LIN2_WAKE_EN_O));
endmodule : lcr_chk
bind lcr_top lcr_chk i_lcr_chk (.*);
`default_nettype wire

// [test/lcr_host.sv]
`timescale 1ns/100ps
`default_nettype none
module lcr_host (
  input wire logic clk_i,
  input wire logic miso_i,
  input wire logic miso_oe_i,
  output logic sclk_o,
  output logic cs_n_o,
  output logic mosi_o,
  output logic can_on_o
);
  // Regulator on before any LIN use
  initial begin
    sclk_o = 1'b0;
    cs_n_o = 1'b1;
    mosi_o = 1'b0;
    can_on_o = 1'b1;
  end
  task automatic set_can(input logic v);
    can_on_o = v;
  endtask : set_can
  // MSB first, 160 ns serial clock, still between frames; the readback bit
  // is taken just before each rising serial clock edge
  task automatic send(input logic [15:0] f, input int nb,
                      output logic [15:0] rx);
    rx = 16'h0000;
    cs_n_o = 1'b0;
    for (int i = 0; i < nb; i++) begin
      mosi_o = f[15-i];
      repeat (8) @(negedge clk_i);
      rx[15-i] = miso_oe_i ? miso_i : 1'bx;
      sclk_o = 1'b1;
      repeat (8) @(negedge clk_i);
      sclk_o = 1'b0;
    end
    repeat (8) @(negedge clk_i);
    cs_n_o = 1'b1;
    // Released line must not keep showing a valid bit
    mosi_o = ~mosi_o;
    repeat (12) @(negedge clk_i);
  endtask : send
endmodule : lcr_host
`default_nettype wire

// [test/tb_top.sv]
`timescale 1ns/100ps
`default_nettype none
module tb_top;
  import lcr_pkg::*;
  logic MCLK_I, RESETN_I, SPI_SCLK_I, SPI_CS_N_I, SPI_MOSI_I;
  logic SPI_MISO_O, SPI_MISO_OE_O, LIN1_TXD_I, LIN2_TXD_I;
  logic SUPPLY_HALF_LOW_I, CAN_SUPPLY_REGULATOR_ON_I;
  logic CE_I = 1'b1;
  logic LIN1_TRX_EN_O, LIN1_WAKE_EN_O, LIN1_TERM_EN_O, LIN1_FORCE_REC_O;
  logic LIN2_TRX_EN_O, LIN2_WAKE_EN_O, LIN2_TERM_EN_O, LIN2_FORCE_REC_O;
  logic [1:0] LIN1_SLEW_O, LIN2_SLEW_O;
  int err_total = 0;
  int checked = 0;
  logic [15:0] rd_word;
  lcr_top i_lcr_top (.*);
  lcr_host i_lcr_host (.clk_i(MCLK_I), .miso_i(SPI_MISO_O),
    .miso_oe_i(SPI_MISO_OE_O), .sclk_o(SPI_SCLK_I),
    .cs_n_o(SPI_CS_N_I), .mosi_o(SPI_MOSI_I),
    .can_on_o(CAN_SUPPLY_REGULATOR_ON_I));
  initial begin
    MCLK_I = 1'b0;
    forever #5 MCLK_I = ~MCLK_I;
  end
  ////////////////////////////////////////////////////////////////////////////
  task automatic close_out;
    $display("mismatches %0d of %0d checks", err_total, checked);
    if (err_total == 0 && checked > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask : close_out
  task automatic cmp(input logic [15:0] g, input logic [15:0] e);
    checked++;
    if (g !== e) begin
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, g, e);
      err_total++;
    end
  endtask : cmp
  // Expected outputs follow from the stored byte, with the forced-recessive bit given separately
  task automatic chk(input logic c, input logic [7:0] d, input logic f);
    cmp(c ? {LIN2_TRX_EN_O, LIN2_WAKE_EN_O, LIN2_SLEW_O, LIN2_TERM_EN_O,
      LIN2_FORCE_REC_O} : {LIN1_TRX_EN_O, LIN1_WAKE_EN_O, LIN1_SLEW_O,
      LIN1_TERM_EN_O, LIN1_FORCE_REC_O}, {d[7:6] == 2'b11,
      d[7:6] == 2'b10, d[5] ? 2'b10 : d[5:4], d[2], f});
  endtask : chk
  task automatic wr(input logic [4:0] a, input logic [7:0] d,
    input logic [1:0] p = 2'b01, input int nb = 16);
    i_lcr_host.send({p, a, 1'b0, d}, nb, rd_word);
  endtask : wr
  ////////////////////////////////////////////////////////////////////////////
  task automatic t_fields;
    logic [7:0] v[4] = '{8'hC4, 8'h90, 8'h2A, 8'h7F};
    foreach (v[i]) begin
      wr(LCR_ADDR_LIN_FIRST, v[i]);
      chk(1'b0, v[i], 1'b0);
    end
  endtask : t_fields
  task automatic t_chan2;
    wr(LCR_ADDR_LIN_SECOND, 8'hB4);
    cmp(rd_word, 16'h7500);
    chk(1'b1, 8'hB4, 1'b0);
    chk(1'b0, 8'h7F, 1'b0);
  endtask : t_chan2
  task automatic t_refuse;
    LIN1_TXD_I = 1'b0;
    wr(LCR_ADDR_LIN_FIRST, 8'hC4);
    chk(1'b0, 8'h44, 1'b0);
    LIN1_TXD_I = 1'b1;
    wr(LCR_ADDR_LIN_FIRST, 8'hC4);
    chk(1'b0, 8'hC4, 1'b0);
  endtask : t_refuse
  // Short frame, wrong prefix and foreign address must all be dropped
  task automatic t_frames;
    wr(LCR_ADDR_LIN_FIRST, 8'h00, 2'b11);
    cmp(rd_word, 16'hC4B4);
    wr(LCR_ADDR_LIN_FIRST, 8'h00, 2'b01, 15);
    wr(5'h15, 8'h00);
    cmp(SPI_MISO_OE_O, 1'b0);
    chk(1'b0, 8'hC4, 1'b0);
    chk(1'b1, 8'hB4, 1'b0);
  endtask : t_frames
  task automatic t_supply;
    SUPPLY_HALF_LOW_I = 1'b1;
    repeat (10) @(negedge MCLK_I);
    chk(1'b0, 8'hC4, 1'b1);
    wr(LCR_ADDR_LIN_FIRST, 8'hC5);
    chk(1'b0, 8'hC5, 1'b0);
    i_lcr_host.set_can(1'b0);
    repeat (10) @(negedge MCLK_I);
    chk(1'b0, 8'hC5, 1'b1);
  endtask : t_supply
  // Reset in mid-run clears written registers; supply is still low here
  task automatic t_reset;
    RESETN_I = 1'b0;
    repeat (3) @(negedge MCLK_I);
    RESETN_I = 1'b1;
    repeat (6) @(negedge MCLK_I);
    chk(1'b0, 8'h00, 1'b1);
    chk(1'b1, 8'h00, 1'b1);
  endtask : t_reset
  // A low clock enable holds the forced state until it rises again
  task automatic t_hold;
    CE_I = 1'b0;
    SUPPLY_HALF_LOW_I = 1'b0;
    repeat (10) @(negedge MCLK_I);
    chk(1'b0, 8'h00, 1'b1);
    CE_I = 1'b1;
    repeat (10) @(negedge MCLK_I);
    chk(1'b0, 8'h00, 1'b0);
  endtask : t_hold
  ////////////////////////////////////////////////////////////////////////////
  initial begin
    RESETN_I = 1'b0;
    LIN1_TXD_I = 1'b1;
    LIN2_TXD_I = 1'b1;
    SUPPLY_HALF_LOW_I = 1'b0;
    repeat (12) @(negedge MCLK_I);
    RESETN_I = 1'b1;
    repeat (6) @(negedge MCLK_I);
    chk(1'b0, 8'h00, 1'b0);
    chk(1'b1, 8'h00, 1'b0);
    t_fields();
    t_chan2();
    t_refuse();
    t_frames();
    t_supply();
    t_reset();
    t_hold();
    close_out();
  end
  initial begin
    #200_000;
    err_total++;
    close_out();
  end
endmodule : tb_top
`default_nettype wire
